// >>> design/tpo_output_stage.sv
// three-phase pwm output stage: pulse deletion, crossover, disable, chopping, shutdown
// assumes: timing unit on CLK_I supplies raw pins, sync and half flag; ahb-lite master
`timescale 1ns/100ps
`include "tpo_map.svh"

// What this block does
// - double update mode latches separate duty values at both half-period syncs.
// - minimum on-time is the min pulse count times one core clock.
// - each half, short signals are held off and their complement fully on.
// - output steer control register is nine bits, read and write.
// - steer bits 8, 7, 6 enable crossover of phases a, b, c.
// - crossover routes the high signal to the low pin and back.
// - crossover bits reset to zero.
// - steer bits 0 to 5 each hold one output off while set.
// - steer bits 0 and 1 disable both phase c outputs.
// - disable gating follows the crossover swap, on final pin signals.
// - disable bits reset to zero, all outputs enabled.
// - steer settings take effect only at sync latch, also mid-cycle in double mode.
// - gate chop bit 8 chops the three high-side outputs.
// - gate chop bit 9 chops the three low-side outputs.
// - chop divider bits 0 to 7 give carrier period four times divider plus one.
// - gate chop register resets to zero, chopping off.
// - fault falling edge forces all outputs off asynchronously.
// - shutdown stops the sync pulse and raises a fault interrupt.
// - status bit 0 shows the current fault input level.
// - sync pulses twice per period in double mode, once in single.
// - soft trip write shuts down like a fault; read reports source and clears.
// - current sense trip is ored into the fault input, same shutdown.
// - restart needs period and three duty writes; new duty latches at next sync.
module tpo_output_stage #(
   parameter int DW = 16
) (
   input  wire logic          CLK_I,
   input  wire logic          ARST_N_I,
   input  wire logic          FAULT_TRIP_N_I,
   input  wire logic          CURRENT_SENSE_N_I,
   input  wire logic [2:0]    TU_HI_I,
   input  wire logic [2:0]    TU_LO_I,
   input  wire logic          SYNC_I,
   input  wire logic          HALF_I,
   input  wire logic          HSEL_I,
   input  wire logic [31:0]   HADDR_I,
   input  wire logic [1:0]    HTRANS_I,
   input  wire logic          HWRITE_I,
   input  wire logic [2:0]    HSIZE_I,
   input  wire logic [31:0]   HWDATA_I,
   input  wire logic          HREADY_I,
   output logic [31:0]        HRDATA_O,
   output logic               HREADYOUT_O,
   output logic               HRESP_O,
   output logic [2:0]         PWM_HI_O,
   output logic [2:0]         PWM_LO_O,
   output logic               CYCLE_SYNC_O,
   output logic               FAULT_IRQ_O
);

   // on-time x - y - z, signed so an underflow counts as too short
   // register window check, shared by the decode and the read path
   function automatic logic in_window(input logic [31:0] a);
      return a[31:8] == 24'h0;
   endfunction : in_window

   function automatic logic too_short(input logic [DW-1:0] x,
                                      input logic [DW-1:0] y,
                                      input logic [DW-1:0] z,
                                      input logic [DW-1:0] m);
      logic signed [DW+1:0] t;
      t = $signed({2'b00, x}) - $signed({2'b00, y}) - $signed({2'b00, z});
      return t < $signed({2'b00, m});
   endfunction : too_short

   logic [8:0]          steer_r;
   logic [8:0]          steer_lat_r;
   logic [9:0]          gate_r;
   logic [DW-1:0]       minp_r;
   logic [DW-1:0]       period_r;
   logic [DW-1:0]       dead_r;
   logic [DW-1:0]       duty_r [3];
   logic                double_r;
   logic                soft_r;
   logic [3:0]          seen_r;
   logic                run_r;
   logic [2:0]          del_hi_r;
   logic [2:0]          del_lo_r;
   logic [8:0]          chop_cnt_r;
   logic                carrier_r;
   logic                sync_d_r;
   logic                flt_s1_r;
   logic                flt_s2_r;
   logic                flt_s3_r;
   tpo_pkg::tpo_dphase_t dph_r;
   logic                dph_v_r;
   tpo_pkg::tpo_pins_t  kept;
   tpo_pkg::tpo_pins_t  steered;
   tpo_pkg::tpo_pins_t  gated;
   tpo_pkg::tpo_pins_t  pins;
   logic [2:0]          hi_short;
   logic [2:0]          lo_short;
   logic                soft_hit;
   logic                kill_n;
   logic                take;
   logic                wr_en;
   logic                soft_wr;
   logic                soft_rd;
   logic                latch;
   logic [31:0]         rdata_nxt;

   // shutdown path is pure gating, no clock involved
   assign kill_n  = ARST_N_I & FAULT_TRIP_N_I & CURRENT_SENSE_N_I;
   assign take    = HSEL_I & HTRANS_I[1] & HREADY_I;
   assign wr_en   = dph_v_r & dph_r.wr;
   assign soft_wr = wr_en & (dph_r.addr == `TPO_OFF_SOFT);
   assign soft_hit = soft_wr & HWDATA_I[0];
   assign soft_rd = take & ~HWRITE_I & (HADDR_I[7:0] == `TPO_OFF_SOFT) & in_window(HADDR_I);
   // single mode ignores the mid-period sync
   assign latch   = SYNC_I & ~sync_d_r & (double_r | ~HALF_I);

   // ahb-lite address phase capture; zero wait states
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         dph_v_r <= 1'b0;
         dph_r   <= '0;
      end else begin
         dph_v_r <= take & in_window(HADDR_I);
         dph_r   <= '{wr: HWRITE_I, addr: HADDR_I[7:0]};
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         HREADYOUT_O <= 1'b0;
         HRESP_O     <= 1'b0;
      end else begin
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end
   end

   // software registers
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         steer_r  <= `TPO_STEER_RST;
         gate_r   <= `TPO_GATE_RST;
         minp_r   <= `TPO_MINP_RST;
         period_r <= `TPO_TIME_RST;
         dead_r   <= `TPO_TIME_RST;
         duty_r   <= '{default: `TPO_TIME_RST};
         double_r <= 1'b0;
      end else if (wr_en) begin
         unique case (dph_r.addr)
            `TPO_OFF_STEER:  steer_r   <= HWDATA_I[8:0];
            `TPO_OFF_GATE:   gate_r    <= HWDATA_I[9:0];
            `TPO_OFF_MINP:   minp_r    <= HWDATA_I[DW-1:0];
            `TPO_OFF_PERIOD: period_r  <= HWDATA_I[DW-1:0];
            `TPO_OFF_DUTY_A: duty_r[0] <= HWDATA_I[DW-1:0];
            `TPO_OFF_DUTY_B: duty_r[1] <= HWDATA_I[DW-1:0];
            `TPO_OFF_DUTY_C: duty_r[2] <= HWDATA_I[DW-1:0];
            `TPO_OFF_DEAD:   dead_r    <= HWDATA_I[DW-1:0];
            `TPO_OFF_MODE:   double_r  <= HWDATA_I[0];
            default: ;
         endcase
      end
   end

   // soft trip: set beats the read-clear
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         soft_r <= 1'b0;
      end else if (soft_hit) begin
         soft_r <= 1'b1;
      end else if (soft_rd) begin
         soft_r <= 1'b0;
      end
   end

   // restart bookkeeping; cleared at once by a fault so no stale restart
   always_ff @(posedge CLK_I or negedge kill_n) begin
      if (!kill_n) begin
         seen_r <= 4'h0;
      end else if (soft_hit) begin
         seen_r <= 4'h0;
      end else if (wr_en) begin
         if (dph_r.addr == `TPO_OFF_PERIOD) seen_r[0] <= 1'b1;
         if (dph_r.addr == `TPO_OFF_DUTY_A) seen_r[1] <= 1'b1;
         if (dph_r.addr == `TPO_OFF_DUTY_B) seen_r[2] <= 1'b1;
         if (dph_r.addr == `TPO_OFF_DUTY_C) seen_r[3] <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I or negedge kill_n) begin
      if (!kill_n) begin
         run_r <= 1'b0;
      end else if (soft_hit) begin
         run_r <= 1'b0;
      end else if (&seen_r) begin
         run_r <= 1'b1;
      end
   end

   // fault level into the clock domain, for status and interrupt only
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         flt_s1_r <= 1'b1;
         flt_s2_r <= 1'b1;
         flt_s3_r <= 1'b1;
      end else begin
         flt_s1_r <= FAULT_TRIP_N_I & CURRENT_SENSE_N_I;
         flt_s2_r <= flt_s1_r;
         flt_s3_r <= flt_s2_r;
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         FAULT_IRQ_O <= 1'b0;
      end else begin
         FAULT_IRQ_O <= (flt_s3_r & ~flt_s2_r) | soft_hit;
      end
   end

   // deletion decisions from the live registers; only a latch captures them
   always_comb begin
      hi_short = 3'h0;
      lo_short = 3'h0;
      for (int p = 0; p < 3; p++) begin
         // high short wins; only otherwise is the low side checked
         hi_short[p] = too_short(duty_r[p], dead_r, '0, minp_r);
         lo_short[p] = ~hi_short[p] & too_short(period_r, duty_r[p], dead_r, minp_r);
      end
   end

   // sync latch of steering and per-half deletion decisions
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sync_d_r    <= 1'b0;
         steer_lat_r <= `TPO_STEER_RST;
         del_hi_r    <= 3'h0;
         del_lo_r    <= 3'h0;
      end else begin
         sync_d_r <= SYNC_I;
         if (latch) begin
            steer_lat_r <= steer_r;
            // duty of this half is used; in double mode it may differ per half
            del_hi_r    <= hi_short;
            del_lo_r    <= lo_short;
         end
      end
   end

   // carrier toggles every 2*(div+1) clocks; divider assumed static while running
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         chop_cnt_r <= 9'h000;
         carrier_r  <= 1'b0;
      end else if (chop_cnt_r >= {gate_r[`TPO_DIV_MSB:0], 1'b1}) begin
         chop_cnt_r <= 9'h000;
         carrier_r  <= ~carrier_r;
      end else begin
         chop_cnt_r <= chop_cnt_r + 9'h001;
      end
   end

   // pin path stage 1: deletion forces a pair to one side for the whole half
   always_comb begin
      kept = '{hi: TU_HI_I, lo: TU_LO_I};
      for (int p = 0; p < 3; p++) begin
         if (del_hi_r[p]) begin
            kept.hi[p] = 1'b0;
            kept.lo[p] = 1'b1;
         end else if (del_lo_r[p]) begin
            kept.hi[p] = 1'b1;
            kept.lo[p] = 1'b0;
         end
      end
   end

   // stage 2: crossover swaps a pair before any gating sees it
   always_comb begin
      steered = kept;
      for (int p = 0; p < 3; p++) begin
         if (steer_lat_r[`TPO_XOVER_A_BIT - p]) begin
            steered.hi[p] = kept.lo[p];
            steered.lo[p] = kept.hi[p];
         end
      end
   end

   // stage 3: disable acts on the final pin signals, after the swap
   always_comb begin
      gated = steered;
      for (int p = 0; p < 3; p++) begin
         gated.hi[p] = steered.hi[p] & ~steer_lat_r[`TPO_DIS_A_HI_BIT - 2 * p];
         gated.lo[p] = steered.lo[p] & ~steer_lat_r[`TPO_DIS_A_LO_BIT - 2 * p];
      end
   end

   // stage 4: chop the active side; a low pin stays low whatever the carrier
   always_comb begin
      pins = gated;
      if (gate_r[`TPO_CHOP_HI_BIT]) pins.hi = gated.hi & {3{carrier_r}};
      if (gate_r[`TPO_CHOP_LO_BIT]) pins.lo = gated.lo & {3{carrier_r}};
   end

   // pin flops cleared straight by the fault, not by the clock
   always_ff @(posedge CLK_I or negedge kill_n) begin
      if (!kill_n) begin
         PWM_HI_O     <= 3'h0;
         PWM_LO_O     <= 3'h0;
         CYCLE_SYNC_O <= 1'b0;
      end else begin
         PWM_HI_O     <= pins.hi & {3{run_r}};
         PWM_LO_O     <= pins.lo & {3{run_r}};
         CYCLE_SYNC_O <= latch & run_r;
      end
   end

   // read mux, evaluated in the address phase
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (HADDR_I[7:0])
         `TPO_OFF_STEER:  rdata_nxt[8:0]    = steer_r;
         `TPO_OFF_GATE:   rdata_nxt[9:0]    = gate_r;
         `TPO_OFF_MINP:   rdata_nxt[DW-1:0] = minp_r;
         `TPO_OFF_PERIOD: rdata_nxt[DW-1:0] = period_r;
         `TPO_OFF_DUTY_A: rdata_nxt[DW-1:0] = duty_r[0];
         `TPO_OFF_DUTY_B: rdata_nxt[DW-1:0] = duty_r[1];
         `TPO_OFF_DUTY_C: rdata_nxt[DW-1:0] = duty_r[2];
         `TPO_OFF_DEAD:   rdata_nxt[DW-1:0] = dead_r;
         `TPO_OFF_MODE:   rdata_nxt[0]      = double_r;
         `TPO_OFF_STATUS: begin
            rdata_nxt[`TPO_STAT_FAULT_BIT] = flt_s2_r;
            rdata_nxt[`TPO_STAT_RUN_BIT]   = run_r;
            rdata_nxt[`TPO_STAT_HALF_BIT]  = HALF_I;
         end
         `TPO_OFF_SOFT:   rdata_nxt[0]      = soft_r;
         default: ;
      endcase
      // unmapped space reads zero rather than aliasing a register
      if (!in_window(HADDR_I)) rdata_nxt = 32'h0000_0000;
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         HRDATA_O <= 32'h0000_0000;
      end else if (take && !HWRITE_I) begin
         HRDATA_O <= rdata_nxt;
      end
   end

endmodule : tpo_output_stage

// >>> design/tpo_map.svh
// offsets, field positions, reset values and timing figures of the pwm output stage
// assumes: byte addresses on a 32-bit ahb-lite bus, one aligned word per register
`ifndef TPO_MAP_SVH
`define TPO_MAP_SVH
`define TPO_TCK_NS         50
`define TPO_CHOP_MUL       4
`define TPO_OFF_STEER      8'h00
`define TPO_OFF_GATE       8'h04
`define TPO_OFF_MINP       8'h08
`define TPO_OFF_PERIOD     8'h0c
`define TPO_OFF_DUTY_A     8'h10
`define TPO_OFF_DUTY_B     8'h14
`define TPO_OFF_DUTY_C     8'h18
`define TPO_OFF_DEAD       8'h1c
`define TPO_OFF_MODE       8'h20
`define TPO_OFF_STATUS     8'h24
`define TPO_OFF_SOFT       8'h28
`define TPO_XOVER_A_BIT    8
`define TPO_DIS_A_HI_BIT   4
`define TPO_DIS_A_LO_BIT   5
`define TPO_CHOP_HI_BIT    8
`define TPO_CHOP_LO_BIT    9
`define TPO_DIV_MSB        7
`define TPO_STAT_FAULT_BIT 0
`define TPO_STAT_RUN_BIT   1
`define TPO_STAT_HALF_BIT  3
`define TPO_STEER_RST      9'h000
`define TPO_GATE_RST       10'h000
`define TPO_MINP_RST       16'h0000
`define TPO_TIME_RST       16'h0000
`endif

// >>> design/tpo_pkg.sv
// types shared by the pwm output stage
// assumes: constants come from tpo_map.svh
package tpo_pkg;
   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } tpo_pins_t;
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
   } tpo_dphase_t;
endpackage : tpo_pkg

// >>> dv/tpo_output_stage_asserts.sv
// checker for the pwm output stage: shutdown, trip interrupt, sync pulse
// assumes: bound to tpo_output_stage, one clock domain
`timescale 1ns/100ps
module tpo_output_stage_asserts (
   input wire logic       CLK_I,
   input wire logic       ARST_N_I,
   input wire logic       FAULT_TRIP_N_I,
   input wire logic       CURRENT_SENSE_N_I,
   input wire logic       SYNC_I,
   input wire logic [2:0] PWM_HI_O,
   input wire logic [2:0] PWM_LO_O,
   input wire logic       CYCLE_SYNC_O,
   input wire logic       FAULT_IRQ_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);
   wire logic ok  = FAULT_TRIP_N_I & CURRENT_SENSE_N_I;
   wire logic off = {PWM_HI_O, PWM_LO_O} == 6'h0;
   // irq lags the trip by the synchroniser and edge detect
   sequence s_irq; ##[1:5] FAULT_IRQ_O; endsequence
   sequence s_idle; off [*4]; endsequence
   property p_pin_off; !FAULT_TRIP_N_I |-> off; endproperty
   a_pin_off: assert property (p_pin_off) else $error("pins on in fault");
   property p_sense_off; !CURRENT_SENSE_N_I |-> off; endproperty
   a_sense_off: assert property (p_sense_off) else $error("pins on in trip");
   property p_irq; $fell(ok) |-> s_irq; endproperty
   a_irq: assert property (p_irq) else $error("no trip interrupt");
   property p_irq_once; FAULT_IRQ_O |=> !FAULT_IRQ_O; endproperty
   a_irq_once: assert property (p_irq_once) else $error("long trip pulse");
   property p_no_sync; !ok |-> !CYCLE_SYNC_O; endproperty
   a_no_sync: assert property (p_no_sync) else $error("sync in fault");
   // no restart writes can land this soon after release
   property p_idle; $rose(ok) |-> s_idle; endproperty
   a_idle: assert property (p_idle) else $error("pins on before restart");
   property p_sync_src;
      CYCLE_SYNC_O |-> $past(SYNC_I) || $past(SYNC_I, 2) || $past(SYNC_I, 3);
   endproperty
   a_sync_src: assert property (p_sync_src) else $error("sync without cause");
   property p_sync_once; CYCLE_SYNC_O |=> !CYCLE_SYNC_O; endproperty
   a_sync_once: assert property (p_sync_once) else $error("long sync pulse");
endmodule : tpo_output_stage_asserts

bind tpo_output_stage tpo_output_stage_asserts i_tpo_output_stage_asserts (
   .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .FAULT_TRIP_N_I(FAULT_TRIP_N_I),
   .CURRENT_SENSE_N_I(CURRENT_SENSE_N_I), .SYNC_I(SYNC_I), .PWM_HI_O(PWM_HI_O),
   .PWM_LO_O(PWM_LO_O), .CYCLE_SYNC_O(CYCLE_SYNC_O), .FAULT_IRQ_O(FAULT_IRQ_O));

// >>> dv/tpo_fault_sensor.sv
// fault sensor model: external trip line and current-sense comparator
// assumes: trip commands change just after a rising clock edge
`timescale 1ns/100ps
module tpo_fault_sensor (
   input  wire logic [1:0] trip_i,
   output logic            fault_n_o,
   output logic            sense_n_o
);
   // no clock: the trip must reach the pins without one
   assign fault_n_o = ~trip_i[0];
   assign sense_n_o = ~trip_i[1];
endmodule : tpo_fault_sensor

// >>> dv/test_three_phase_pwm_output_stage.sv
// bench for the pwm output stage: registers, steering, deletion, chop, shutdown
// assumes: checker bound; the bench stands in for the timing unit
`timescale 1ns/100ps
`include "tpo_map.svh"
module test_three_phase_pwm_output_stage;
   logic        clk, arst_n, sync, half, hwrite, ready, resp, sync_o, irq, f_n, s_n;
   logic [1:0]  htrans, trip;
   logic [2:0]  tu_hi, tu_lo, hi, lo, eh, el;
   logic [31:0] haddr, hwdata, hrdata, d;
   int          fails, n_compared, cyc, nsync, nirq, n0, ch, cl;
   tpo_output_stage i_tpo_output_stage (
      .CLK_I(clk), .ARST_N_I(arst_n), .FAULT_TRIP_N_I(f_n), .CURRENT_SENSE_N_I(s_n),
      .TU_HI_I(tu_hi), .TU_LO_I(tu_lo), .SYNC_I(sync), .HALF_I(half), .HSEL_I(1'b1),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
      .HWDATA_I(hwdata), .HREADY_I(ready), .HRDATA_O(hrdata), .HREADYOUT_O(ready),
      .HRESP_O(resp), .PWM_HI_O(hi), .PWM_LO_O(lo), .CYCLE_SYNC_O(sync_o),
      .FAULT_IRQ_O(irq));
   tpo_fault_sensor i_tpo_fault_sensor (.trip_i(trip), .fault_n_o(f_n), .sense_n_o(s_n));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) begin
      if (sync_o === 1'b1) nsync++;
      if (irq === 1'b1) nirq++;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
   end
   task automatic test_done();
      if (fails == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // address phase held until ready, then data phase likewise
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (ready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= v;
      do @(posedge clk); while (ready !== 1'b1);
      d = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, a, v);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(d & m, e);
   endtask : rc
   task automatic sy(input logic h);
      half <= h;
      sync <= 1'b1;
      @(posedge clk);
      sync <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : sy
   task automatic pc(input logic [5:0] e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({26'h0, hi, lo}, {26'h0, e});
      @(posedge clk);
   endtask : pc
   task automatic start();
      for (int i = 0; i < 4; i++) begin
         wr(`TPO_OFF_PERIOD + 8'(4 * i), (i == 0) ? 32'd200 : 32'd50);
      end
      @(posedge clk);
   endtask : start
   initial begin
      {sync, half, hwrite, htrans, trip, tu_hi, tu_lo} = '0;
      haddr = '0;
      hwdata = '0;
      arst_n = 1'b0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rc(`TPO_OFF_STEER, '1, 32'h0);
      rc(`TPO_OFF_GATE, '1, 32'h0);
      wr(`TPO_OFF_STEER, 32'hffff);
      rc(`TPO_OFF_STEER, '1, 32'h1ff);
      wr(`TPO_OFF_GATE, 32'hffff);
      rc(`TPO_OFF_GATE, '1, 32'h3ff);
      wr(8'h40, 32'hffff);
      rc(8'h40, '1, 32'h0);
      wr(`TPO_OFF_GATE, 32'h0);
      wr(`TPO_OFF_STEER, 32'h0);
      tu_hi <= 3'b101;
      tu_lo <= 3'b010;
      sy(1'b0);
      pc(6'h0);
      start();
      n0 = nsync;
      sy(1'b0);
      chk(nsync - n0, 1);
      {eh, el} = 6'b101010;
      pc({eh, el});
      for (int p = 0; p < 3; p++) begin
         wr(`TPO_OFF_STEER, 32'h100 >> p);
         pc({eh, el});
         sy(1'b0);
         eh = tu_hi;
         el = tu_lo;
         eh[p] = tu_lo[p];
         el[p] = tu_hi[p];
         pc({eh, el});
      end
      wr(`TPO_OFF_STEER, 32'h0);
      n0 = nsync;
      sy(1'b1);
      pc({eh, el});
      wr(`TPO_OFF_MODE, 32'h1);
      sy(1'b1);
      chk(nsync - n0, 1);
      pc(6'b101010);
      tu_hi <= 3'b010;
      tu_lo <= 3'b000;
      wr(`TPO_OFF_STEER, 32'h084);
      sy(1'b0);
      pc(6'b000010);
      tu_hi <= 3'b111;
      tu_lo <= 3'b111;
      wr(`TPO_OFF_STEER, 32'h0a7);
      sy(1'b0);
      pc(6'b001010);
      for (int b = 0; b < 6; b++) begin
         wr(`TPO_OFF_STEER, 32'h1 << b);
         sy(1'b0);
         pc(~(6'h1 << (((b % 2) ? 0 : 3) + 2 - b / 2)));
      end
      wr(`TPO_OFF_STEER, 32'h0);
      wr(`TPO_OFF_DEAD, 32'd3);
      wr(`TPO_OFF_MINP, 32'd10);
      wr(`TPO_OFF_DUTY_A, 32'd5);
      wr(`TPO_OFF_DUTY_B, 32'd13);
      wr(`TPO_OFF_DUTY_C, 32'd190);
      sy(1'b0);
      pc(6'b110011);
      tu_hi <= 3'b000;
      tu_lo <= 3'b000;
      pc(6'b100001);
      wr(`TPO_OFF_DUTY_A, 32'd50);
      sy(1'b1);
      pc(6'b100000);
      tu_hi <= 3'b111;
      tu_lo <= 3'b111;
      for (int s = 0; s < 2; s++) begin
         wr(`TPO_OFF_GATE, (32'h100 << s) | 32'h1);
         repeat (2) @(posedge clk);
         {ch, cl} = '0;
         repeat (16) begin
            @(negedge clk);
            ch += hi[1];
            cl += lo[1];
         end
         chk(ch, s ? 16 : 8);
         chk(cl, s ? 8 : 16);
         @(posedge clk);
      end
      wr(`TPO_OFF_GATE, 32'h0);
      for (int k = 0; k < 2; k++) begin
         start();
         sy(1'b0);
         pc(6'h3f);
         n0 = nirq;
         trip <= 2'b01 << k;
         #1 chk({26'h0, hi, lo}, 32'h0);
         repeat (6) @(posedge clk);
         chk(nirq - n0, 1);
         rc(`TPO_OFF_STATUS, 32'h1, 32'h0);
         n0 = nsync;
         sy(1'b0);
         chk(nsync - n0, 0);
         rc(`TPO_OFF_SOFT, '1, 32'h0);
         trip <= 2'b00;
         repeat (4) @(posedge clk);
         rc(`TPO_OFF_STATUS, 32'h1, 32'h1);
         pc(6'h0);
      end
      start();
      sy(1'b0);
      n0 = nirq;
      wr(`TPO_OFF_SOFT, 32'h1);
      pc(6'h0);
      chk(nirq - n0, 1);
      rc(`TPO_OFF_SOFT, '1, 32'h1);
      rc(`TPO_OFF_SOFT, '1, 32'h0);
      test_done();
   end
endmodule : test_three_phase_pwm_output_stage
